//--- logic/timer_pkg.sv
// shared constants, types and register map of the timer block
package timer_pkg;

  localparam int unsigned NUM_INST = 4;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned ADDR_W = 8;

  // timebase: counters advance once per microsecond
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);

  // duty of ten thousand means fully active
  localparam logic [13:0] DUTY_FULL = 14'h2710;

  // register index inside an instance block; byte offset is index * 4
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_PER_A = 3'h2;
  localparam logic [2:0] REG_PER_B = 3'h3;
  localparam logic [2:0] REG_FREQ_A = 3'h4;
  localparam logic [2:0] REG_FREQ_B = 3'h5;
  localparam logic [2:0] REG_DUTY_A = 3'h6;
  localparam logic [2:0] REG_DUTY_B = 3'h7;

  // control word fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_ON = 3;
  localparam int CTRL_EN_LSB = 4;
  localparam int CTRL_IE_LSB = 6;
  localparam int CTRL_POL_LSB = 8;
  localparam int CTRL_DEINIT = 10;
  localparam int CTRL_PRIO_A_LSB = 12;
  localparam int CTRL_PRIO_B_LSB = 16;

  // status word fields
  localparam int STAT_PEND_LSB = 0;
  localparam int STAT_RUN_LSB = 2;

  typedef enum logic [1:0] {
    MODE_ONE_SHOT = 2'h0,
    MODE_PERIODIC = 2'h1,
    MODE_PWM = 2'h2
  } mode_t;

  typedef struct packed {
    logic [2:0] prio_b;
    logic [2:0] prio_a;
    logic [1:0] pol;
    logic [1:0] ie;
    logic [1:0] en;
    logic on;
    logic wide;
    mode_t mode;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{prio_b: 3'h1, prio_a: 3'h1, pol: 2'h0,
    ie: 2'h0, en: 2'h0, on: 1'b0, wide: 1'b0, mode: MODE_ONE_SHOT};

  typedef struct packed {
    logic [31:0] period;
    logic [13:0] duty;
    logic pol;
    logic pwm;
    logic oneshot;
    logic active;
  } ch_ctl_t;

  typedef enum {CH_IDLE, CH_RUN, CH_DONE} ch_state_t;

endpackage

//--- logic/timer_tick.sv
// microsecond tick generator for all channel counters
`timescale 1ns/1ns
`default_nettype none
module timer_tick
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  output logic tick_q
);

  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic tick_d;

  always_comb begin
    tick_d = (cnt_q == TICK_LAST);
    cnt_d = tick_d ? 7'h0 : cnt_q + 7'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule
`default_nettype wire

//--- logic/timer_channel.sv
// one timer channel: counter, expiry, duty compare and waveform
`timescale 1ns/1ns
`default_nettype none
module timer_channel
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire ch_ctl_t ctl,
  output logic expire_q,
  output logic match_q,
  output logic wave_q,
  output logic run
);

  ch_state_t state_q;
  ch_state_t state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] last;
  logic [45:0] lhs;
  logic [45:0] rhs;
  logic on_q;
  logic on_d;
  logic expire_d;
  logic match_d;
  logic wave_d;
  logic hit;
  logic duty_on;

  always_comb begin
    // period shrunk while running: >= stops a runaway count
    last = (ctl.period == 32'h0) ? 32'h0 : ctl.period - 32'h1;
    hit = tick && (cnt_q >= last);
    // compare without a divider: cnt*10000 < period*duty
    lhs = 46'(cnt_q) * 46'(DUTY_FULL);
    rhs = 46'(ctl.period[15:0]) * 46'(ctl.duty);
    duty_on = (lhs < rhs);
    state_d = state_q;
    cnt_d = cnt_q;
    on_d = on_q;
    expire_d = 1'b0;
    match_d = 1'b0;
    unique case (state_q)
      CH_IDLE: begin
        cnt_d = 32'h0;
        on_d = 1'b0;
        if (ctl.active) begin
          state_d = CH_RUN;
        end
      end
      CH_RUN: begin
        on_d = duty_on;
        match_d = ctl.pwm && on_q && !duty_on;
        if (!ctl.active) begin
          state_d = CH_IDLE;
        end else if (tick) begin
          cnt_d = hit ? 32'h0 : cnt_q + 32'h1;
          expire_d = hit;
          if (hit && ctl.oneshot) begin
            state_d = CH_DONE;
          end
        end
      end
      CH_DONE: begin
        if (!ctl.active) begin
          state_d = CH_IDLE;
        end
      end
    endcase
    // idle level equals the inactive level of the duty portion
    if (state_q == CH_RUN && ctl.pwm && duty_on) begin
      wave_d = !ctl.pol;
    end else begin
      wave_d = ctl.pol;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CH_IDLE;
      cnt_q <= 32'h0;
      on_q <= 1'b0;
      expire_q <= 1'b0;
      match_q <= 1'b0;
      wave_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      on_q <= on_d;
      expire_q <= expire_d;
      match_q <= match_d;
      wave_q <= wave_d;
    end
  end

  assign run = (state_q == CH_RUN);

endmodule
`default_nettype wire

//--- logic/timer_top.sv
// four dual-channel timers with pwm pins behind an apb slave
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - four independent timer instances, index zero to three
// - single-run mode counts one period then stops
// - periodic mode restarts on every expiry
// - pulse-width mode drives a waveform on the channel pin
// - counter width is 16 bits per channel or 32 chained
// - chained 32-bit width only outside pulse-width mode
// - deinit disables channels and interrupts, stops the unit
// - 16-bit: each channel alone; 32-bit: both channels together only
// - channels take their mode from the parent instance
// - polarity sets the active level of the duty portion
// - duty is 0 to 10000 in hundredths of a percent
// - pulse-width mode routes the waveform to its pin automatically
// - periodic mode raises an interrupt at every expiry
// - single-run mode raises an interrupt once at expiry
// - pulse-width mode raises an interrupt at duty compare match
// - interrupt priority levels one to seven, higher wins
// - frequency, period and duty readable and rewritable
module timer_top
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NUM_CH-1:0] pwm_pin,
  output logic [NUM_CH-1:0] pwm_oe,
  output logic [NUM_CH-1:0] irq_pending,
  output logic [2:0] irq_level
);

  cfg_t cfg_q [NUM_INST];
  cfg_t cfg_d [NUM_INST];
  logic [15:0] period_q [NUM_CH];
  logic [15:0] period_d [NUM_CH];
  logic [31:0] freq_q [NUM_CH];
  logic [31:0] freq_d [NUM_CH];
  logic [13:0] duty_q [NUM_CH];
  logic [13:0] duty_d [NUM_CH];
  logic [NUM_CH-1:0] pend_q;
  logic [NUM_CH-1:0] pend_d;
  logic [NUM_CH-1:0] pwm_oe_q;
  logic [NUM_CH-1:0] pwm_oe_d;
  logic [2:0] irq_level_q;
  logic [2:0] irq_level_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  logic tick;
  logic [NUM_CH-1:0] expire;
  logic [NUM_CH-1:0] match;
  logic [NUM_CH-1:0] run;
  logic [NUM_CH-1:0] ev;
  logic [NUM_CH-1:0] ie_vec;
  logic [NUM_CH-1:0] clr;
  logic [1:0] sel_inst;
  logic [2:0] sel_reg;
  logic bad_addr;
  logic access;
  logic wr_take;
  logic [31:0] rd;
  logic [2:0] pr;
  logic [13:0] duty_wr;

  function automatic cfg_t decode_cfg(input logic [31:0] w);
    cfg_t c;
    c = CFG_RESET;
    // reserved mode code falls back to single-run
    if (w[CTRL_MODE_LSB +: 2] == 2'h3) begin
      c.mode = MODE_ONE_SHOT;
    end else begin
      c.mode = mode_t'(w[CTRL_MODE_LSB +: 2]);
    end
    c.wide = w[CTRL_WIDE] && (c.mode != MODE_PWM);
    c.on = w[CTRL_ON];
    c.en = w[CTRL_EN_LSB +: 2];
    c.ie = w[CTRL_IE_LSB +: 2];
    c.pol = w[CTRL_POL_LSB +: 2];
    // level zero is not a priority; it reads back as one
    c.prio_a = (w[CTRL_PRIO_A_LSB +: 3] == 3'h0) ? 3'h1
      : w[CTRL_PRIO_A_LSB +: 3];
    c.prio_b = (w[CTRL_PRIO_B_LSB +: 3] == 3'h0) ? 3'h1
      : w[CTRL_PRIO_B_LSB +: 3];
    return c;
  endfunction

  function automatic logic [31:0] cfg_word(input cfg_t c);
    logic [31:0] w;
    w = 32'h0;
    w[CTRL_MODE_LSB +: 2] = c.mode;
    w[CTRL_WIDE] = c.wide;
    w[CTRL_ON] = c.on;
    w[CTRL_EN_LSB +: 2] = c.en;
    w[CTRL_IE_LSB +: 2] = c.ie;
    w[CTRL_POL_LSB +: 2] = c.pol;
    w[CTRL_PRIO_A_LSB +: 3] = c.prio_a;
    w[CTRL_PRIO_B_LSB +: 3] = c.prio_b;
    return w;
  endfunction

  timer_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_q(tick)
  );

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    localparam int I = g / 2;
    localparam int B = g % 2;
    ch_ctl_t ctl;
    always_comb begin
      // chained mode: only the pair selection runs, on channel a
      if (cfg_q[I].wide) begin
        ctl.active = cfg_q[I].on && (B == 0)
          && (cfg_q[I].en == 2'h3);
        ctl.period = {period_q[2*I+1], period_q[2*I]};
      end else begin
        ctl.active = cfg_q[I].on && cfg_q[I].en[B];
        ctl.period = {16'h0, period_q[g]};
      end
      ctl.oneshot = (cfg_q[I].mode == MODE_ONE_SHOT);
      ctl.pwm = (cfg_q[I].mode == MODE_PWM);
      ctl.pol = cfg_q[I].pol[B];
      ctl.duty = duty_q[g];
    end
    timer_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .ctl(ctl),
      .expire_q(expire[g]),
      .match_q(match[g]),
      .wave_q(pwm_pin[g]),
      .run(run[g])
    );
    // event source follows the mode of the instance
    assign ev[g] = ctl.pwm ? match[g] : expire[g];
    assign ie_vec[g] = cfg_q[I].ie[B];
    assign pwm_oe_d[g] = cfg_q[I].on && ctl.pwm
      && cfg_q[I].en[B];
  end

  always_comb begin
    sel_inst = paddr[6:5];
    sel_reg = paddr[4:2];
    bad_addr = paddr[7] || (paddr[1:0] != 2'h0);
    access = psel && penable;
    wr_take = access && pready_q && pwrite && !bad_addr;
    cfg_d = cfg_q;
    period_d = period_q;
    freq_d = freq_q;
    duty_d = duty_q;
    clr = '0;
    duty_wr = (pwdata[31:14] != 18'h0 || pwdata[13:0] > DUTY_FULL)
      ? DUTY_FULL : pwdata[13:0];
    if (wr_take) begin
      unique case (sel_reg)
        REG_CTRL: begin
          if (pwdata[CTRL_DEINIT]) begin
            cfg_d[sel_inst] = CFG_RESET;
            clr[{sel_inst, 1'b0} +: 2] = 2'h3;
          end else begin
            cfg_d[sel_inst] = decode_cfg(pwdata);
          end
        end
        REG_STAT: clr[{sel_inst, 1'b0} +: 2] = pwdata[STAT_PEND_LSB +: 2];
        REG_PER_A: period_d[{sel_inst, 1'b0}] = pwdata[15:0];
        REG_PER_B: period_d[{sel_inst, 1'b1}] = pwdata[15:0];
        REG_FREQ_A: freq_d[{sel_inst, 1'b0}] = pwdata;
        REG_FREQ_B: freq_d[{sel_inst, 1'b1}] = pwdata;
        REG_DUTY_A: duty_d[{sel_inst, 1'b0}] = duty_wr;
        REG_DUTY_B: duty_d[{sel_inst, 1'b1}] = duty_wr;
      endcase
    end
    // an event in the clearing cycle survives the clear
    pend_d = (pend_q & ~clr) | (ev & ie_vec);
  end

  always_comb begin
    rd = 32'h0;
    unique case (sel_reg)
      REG_CTRL: rd = cfg_word(cfg_q[sel_inst]);
      REG_STAT: begin
        rd[STAT_PEND_LSB +: 2] = pend_q[{sel_inst, 1'b0} +: 2];
        rd[STAT_RUN_LSB +: 2] = run[{sel_inst, 1'b0} +: 2];
      end
      REG_PER_A: rd = {16'h0, period_q[{sel_inst, 1'b0}]};
      REG_PER_B: rd = {16'h0, period_q[{sel_inst, 1'b1}]};
      REG_FREQ_A: rd = freq_q[{sel_inst, 1'b0}];
      REG_FREQ_B: rd = freq_q[{sel_inst, 1'b1}];
      REG_DUTY_A: rd = {18'h0, duty_q[{sel_inst, 1'b0}]};
      REG_DUTY_B: rd = {18'h0, duty_q[{sel_inst, 1'b1}]};
    endcase
    // one wait state lets read data come from a flip-flop
    pready_d = access && !pready_q;
    pslverr_d = access && !pready_q && bad_addr;
    prdata_d = prdata_q;
    if (access && !pready_q && !pwrite) begin
      prdata_d = bad_addr ? 32'h0 : rd;
    end
  end

  always_comb begin
    irq_level_d = 3'h0;
    pr = 3'h0;
    for (int k = 0; k < NUM_CH; k++) begin
      pr = k[0] ? cfg_q[k >> 1].prio_b : cfg_q[k >> 1].prio_a;
      if (pend_q[k] && ie_vec[k] && pr > irq_level_d) begin
        irq_level_d = pr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < NUM_INST; k++) begin
        cfg_q[k] <= CFG_RESET;
      end
      for (int k = 0; k < NUM_CH; k++) begin
        period_q[k] <= 16'h0;
        freq_q[k] <= 32'h0;
        duty_q[k] <= 14'h0;
      end
      pend_q <= '0;
      pwm_oe_q <= '0;
      irq_level_q <= 3'h0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      period_q <= period_d;
      freq_q <= freq_d;
      duty_q <= duty_d;
      pend_q <= pend_d;
      pwm_oe_q <= pwm_oe_d;
      irq_level_q <= irq_level_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pwm_oe = pwm_oe_q;
  assign irq_pending = pend_q;
  assign irq_level = irq_level_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_deinit_wr;
    wr_take && sel_reg == REG_CTRL && pwdata[CTRL_DEINIT] && sel_inst == 2'h3;
  endsequence

  sequence s_oneshot_exp;
    expire[4] && cfg_q[2].mode == MODE_ONE_SHOT;
  endsequence

  a_tick_spacing: assert property (
    tick |=> (!tick)[*8] ##117 tick)
    else $error("tick spacing is not 125 cycles");

  a_oneshot_stops: assert property (
    s_oneshot_exp |-> !run[4] ##1 !expire[4])
    else $error("single-run channel kept counting after expiry");

  a_periodic_keeps: assert property (
    expire[0] && cfg_q[0].mode == MODE_PERIODIC |-> run[0])
    else $error("periodic channel stopped at expiry");

  a_pend_set: assert property (
    ev[0] && ie_vec[0] |=> pend_q[0])
    else $error("enabled event did not set pending flag");

  a_pend_sticky: assert property (
    pend_q[0] && !clr[0] |=> pend_q[0])
    else $error("pending flag dropped without a clear");

  a_deinit_stops: assert property (
    s_deinit_wr |=> !cfg_q[3].on ##1 (pwm_oe_q[7:6] == 2'h0 && !run[6]))
    else $error("deinit left instance three running");

  a_wide_no_pwm: assert property (
    cfg_q[3].mode == MODE_PWM |-> !cfg_q[3].wide)
    else $error("chained width set in pulse-width mode");

  a_b_quiet_wide: assert property (
    (cfg_q[0].wide)[*2] |-> !run[1])
    else $error("channel b ran alone in chained width");

  a_irq_cause: assert property (
    irq_level_q != 3'h0 |-> $past(pend_q & ie_vec) != '0)
    else $error("interrupt level without pending enabled flag");

  a_duty_zero: assert property (
    (cfg_q[3].mode == MODE_PWM && duty_q[6] == 14'h0)[*2]
      |-> pwm_pin[6] == $past(cfg_q[3].pol[0]))
    else $error("zero duty drove the active level");

endmodule
`default_nettype wire

//--- sim/testbench.sv
// self-checking bench for the four-instance timer block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_CH-1:0] pwm_pin;
  logic [NUM_CH-1:0] pwm_oe;
  logic [NUM_CH-1:0] irq_pending;
  logic [2:0] irq_level;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] reg_m [256];
  logic [31:0] seed = 32'h00013fe6;
  logic [31:0] rv;
  logic [31:0] re;
  int cyc;
  int duty_t [4] = '{0, 5000, 10000, 2500};
  logic pol_t [4] = '{1'b0, 1'b0, 1'b1, 1'b1};

  always #4 pclk = ~pclk;

  timer_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_pin(pwm_pin), .pwm_oe(pwm_oe), .irq_pending(irq_pending),
    .irq_level(irq_level));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic results();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input int a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a[7:0];
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    re = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register model: reserved mode, pwm width, priority clamp, saturation
  task automatic wr(input int a, input logic [31:0] d);
    apb(1'b1, a, d);
    case (a % 32)
      0: begin
        reg_m[a] = d & 32'h000773ff;
        if (d[1:0] == 2'h3) reg_m[a][1:0] = 2'h0;
        if (reg_m[a][1:0] == 2'h2) reg_m[a][2] = 1'b0;
        if (d[14:12] == 3'h0) reg_m[a][12] = 1'b1;
        if (d[18:16] == 3'h0) reg_m[a][16] = 1'b1;
        if (d[10]) reg_m[a] = 32'h00011000;
      end
      8, 12: reg_m[a] = d & 32'h0000ffff;
      24, 28: reg_m[a] = (d > 32'h2710) ? 32'h2710 : d;
      default: reg_m[a] = d;
    endcase
  endtask

  task automatic rd(input int a);
    apb(1'b0, a, 32'h0);
    chk(rv, reg_m[a]);
  endtask

  task automatic wait_pend(input int idx, input int lo, input int hi);
    cyc = 0;
    while (irq_pending[idx] !== 1'b1 && cyc < hi + 10) begin
      @(posedge pclk);
      cyc++;
    end
    chk(32'(cyc >= lo && cyc <= hi), 32'h1);
  endtask

  initial begin
    for (int i = 0; i < 256; i++) reg_m[i] = 32'h0;
    for (int i = 0; i < 4; i++) reg_m[i*32] = 32'h00011000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pwm_oe, irq_pending, 13'h0, irq_level}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(i*32);
      wr(i*32+8, rnd());
      wr(i*32+20, rnd());
    end
    for (int i = 0; i < 4; i++) begin
      rd(i*32+8);
      rd(i*32+20);
    end
    apb(1'b0, 8'h80, 32'h0);
    chk({rv[30:0], re[0]}, 32'h1);
    apb(1'b1, 8'h0a, 32'h5);
    chk(re, 32'h1);
    rd(8);
    wr(24, 32'h3fff);
    rd(24);
    wr(32, 32'h00000003);
    rd(32);
    // periodic on instance 1 channel B, priority 5
    wr(44, 32'h3);
    wr(32, 32'h000510a9);
    wait_pend(3, 250, 381);
    repeat (2) @(posedge pclk);
    chk(irq_level, 32'h5);
    apb(1'b0, 36, 32'h0);
    chk(rv[3:0], 32'ha);
    wr(36, 32'h2);
    @(posedge pclk);
    chk(irq_pending[3], 32'h0);
    wait_pend(3, 0, 381);
    // single run on instance 2 channel A
    wr(72, 32'h2);
    wr(64, 32'h00011058);
    wait_pend(4, 125, 256);
    apb(1'b0, 68, 32'h0);
    chk(rv[3:0], 32'h1);
    wr(68, 32'h1);
    repeat (500) @(posedge pclk);
    chk(irq_pending[4], 32'h0);
    // chained width on instance 0, both channels selected
    wr(8, 32'h3);
    wr(12, 32'h0);
    wr(0, 32'h000110fd);
    rd(0);
    wait_pend(0, 250, 381);
    // waveform on instance 3 channel A, period of four ticks
    wr(104, 32'h4);
    for (int k = 0; k < 4; k++) begin
      wr(120, duty_t[k]);
      wr(96, 32'h0001105e | (32'(pol_t[k]) << 8));
      rd(96);
      repeat (600) @(posedge pclk);
      cyc = 0;
      repeat (500) begin
        @(posedge pclk);
        if (pwm_pin[6] === !pol_t[k]) cyc++;
      end
      chk(cyc, (4*duty_t[k]+9999)/10000*125);
      chk(pwm_oe[6], 32'h1);
    end
    chk(irq_pending[6], 32'h1);
    wr(32, 32'h00000400);
    rd(32);
    wr(96, 32'h00000400);
    rd(96);
    @(posedge pclk);
    chk({irq_pending[7:6], irq_pending[3:2], pwm_oe[6]}, 32'h0);
    apb(1'b0, 36, 32'h0);
    chk(rv[3:2], 32'h0);
    results();
  end

  // watchdog: the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
